// File: ec_port_pkg.sv
// Purpose: Shared constants for the echo-canceller port and power-down block.
// Assumes: Core clock clk_sys at 200 MHz; PCM link on its own bit clock.
// Notes:   Register indices sit on a plain port; data words are 16 bits wide.
package ec_port_pkg;

    // Core clock and derived timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_HZ = 200_000_000;
    localparam int BCLK_HZ = 256_000;
    localparam int FS_HZ = 8_000;
    localparam int BCLK_HALF_CYC = CLK_HZ / (2 * BCLK_HZ);
    localparam int BITS_PER_FRAME = BCLK_HZ / FS_HZ;
    localparam int INIT_TIME_US = 100;
    localparam int INIT_CYC = (INIT_TIME_US * 1000) / CLK_PERIOD_NS;

    // PCM sample and bus widths
    localparam int PCM_W = 8;
    localparam int CAS_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_TX_SEND = 4'h2;
    localparam logic [3:0] REG_TX_RECV = 4'h3;
    localparam logic [3:0] REG_RX_SEND = 4'h4;
    localparam logic [3:0] REG_RX_RECV = 4'h5;
    localparam logic [3:0] REG_CAS_OUT = 4'h6;
    localparam logic [3:0] REG_CAS_IN = 4'h7;

    // Control field positions and reset value
    localparam int CTRL_SLAVE = 0;
    localparam int CTRL_CAS_DRIVE = 1;
    localparam int CTRL_FLAG_A = 2;
    localparam int CTRL_FLAG_B = 3;
    localparam int CTRL_CYCLE_DONE = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h0c;

    // Status field positions
    localparam int ST_PD = 0;
    localparam int ST_INIT = 1;
    localparam int ST_HOWL_EN = 2;
    localparam int ST_HOWL_BAD = 3;
    localparam int ST_RX_NEW = 4;
    localparam int ST_CAS_NEW = 5;

    // Synchroniser depth
    localparam int SYNC_STAGES = 3;

endpackage

// File: ec_pcm_link.sv
// Purpose: Serial PCM shifter running on the link bit clock.
// Assumes: Frame sync and serial data are timed to the bit clock.
// Notes:   Words cross to and from the core by toggle handshakes.
`timescale 1ns/10ps
module ec_pcm_link
    import ec_port_pkg::*;
(
    input wire logic sckLink,
    input wire logic haltReq,
    input wire logic frameSyncIn,
    input wire logic sendPcmIn,
    input wire logic recvPcmIn,
    input wire logic [PCM_W-1:0] txSendStage,
    input wire logic [PCM_W-1:0] txRecvStage,
    input wire logic txTgl,
    output logic sendBit,
    output logic recvBit,
    output logic bitOe,
    output logic [PCM_W-1:0] rxSendHold,
    output logic [PCM_W-1:0] rxRecvHold,
    output logic rxTgl,
    output logic txAck
);

    logic [2:0] haltSync_r;
    logic haltF_r;
    logic [2:0] txSync_r;
    logic txSeen_r;
    logic [PCM_W-1:0] txSend_r, txRecv_r, shSend_r, shRecv_r, inSend_r, inRecv_r;
    logic syncPrev_r;
    logic [2:0] outCnt_r, inCnt_r;
    wire frameStart = frameSyncIn && !syncPrev_r;
    wire txChange = (txSync_r[1] == txSync_r[2]) && (txSync_r[2] != txSeen_r);

    // Halt level and tx toggle from the core clock, three flops each
    always_ff @(posedge sckLink) begin
        haltSync_r <= {haltSync_r[1:0], haltReq};
        txSync_r <= {txSync_r[1:0], txTgl};
        if (haltSync_r[1] == haltSync_r[2]) begin
            haltF_r <= haltSync_r[2];
        end
    end

    // Transmit side: load at frame start, shift MSB first on rising edges
    always_ff @(posedge sckLink) begin
        syncPrev_r <= frameSyncIn;
        if (haltF_r) begin
            txSeen_r <= 1'b0;
            txSend_r <= '0;
            txRecv_r <= '0;
        end else if (txChange) begin
            txSeen_r <= txSync_r[2];
            txSend_r <= txSendStage;
            txRecv_r <= txRecvStage;
        end
        if (haltF_r) begin
            bitOe <= 1'b0;
            outCnt_r <= 3'h0;
            shSend_r <= '0;
            shRecv_r <= '0;
        end else if (frameStart) begin
            shSend_r <= txSend_r;
            shRecv_r <= txRecv_r;
            bitOe <= 1'b1;
            outCnt_r <= 3'h0;
        end else if (bitOe) begin
            shSend_r <= {shSend_r[PCM_W-2:0], 1'b0};
            shRecv_r <= {shRecv_r[PCM_W-2:0], 1'b0};
            outCnt_r <= outCnt_r + 3'h1;
            bitOe <= (outCnt_r != 3'h7);
        end
    end

    assign sendBit = shSend_r[PCM_W-1];
    assign recvBit = shRecv_r[PCM_W-1];
    assign txAck = txSeen_r; // Tells the core the staged pair was taken

    // Receive side: sample on falling edges while the frame bits run
    always_ff @(negedge sckLink) begin
        if (haltF_r) begin
            inCnt_r <= 3'h0;
            rxTgl <= 1'b0;
        end else if (!bitOe) begin
            inCnt_r <= 3'h0;
        end else begin
            inSend_r <= {inSend_r[PCM_W-2:0], sendPcmIn};
            inRecv_r <= {inRecv_r[PCM_W-2:0], recvPcmIn};
            inCnt_r <= inCnt_r + 3'h1;
            if (inCnt_r == 3'h7) begin
                rxSendHold <= {inSend_r[PCM_W-2:0], sendPcmIn};
                rxRecvHold <= {inRecv_r[PCM_W-2:0], recvPcmIn};
                rxTgl <= !rxTgl;
            end
        end
    end

    // Output enable holds exactly eight bit times per frame
    property p_frame_len;
        @(posedge sckLink) disable iff (haltF_r)
        $rose(bitOe) |-> bitOe [*8] ##1 !bitOe;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("PCM word not eight bits");

    // A frame start loads the staged sample and drives its MSB
    property p_load;
        @(posedge sckLink) disable iff (haltF_r)
        frameStart |=> bitOe && (sendBit == $past(txSend_r[PCM_W-1]));
    endproperty
    a_load: assert property (p_load) else $error("Frame start did not load sample");

    // The eighth falling edge toggles the word-ready flag
    property p_sample;
        @(negedge sckLink) disable iff (haltF_r)
        (bitOe && inCnt_r == 3'h7) |=> (rxTgl != $past(rxTgl));
    endproperty
    a_sample: assert property (p_sample) else $error("Receive word not handed over");

endmodule // ec_pcm_link

// File: echo_canceler_port.sv
// Purpose: Pin side of the echo canceller: PCM link, cascade bus, power-down.
// Assumes: clk_sys is the basic clock; sckLink is the PCM bit clock.
// Notes:   Power-down, howl and cascade pins pass three flops; a change counts when stages two and three agree.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module echo_canceler_port
    import ec_port_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [DATA_W-1:0] busWrData,
    input wire logic busWr,
    input wire logic busRd,
    output logic [DATA_W-1:0] busRdData,
    input wire logic power_down_n,
    input wire logic howl_detector_ctrl_n,
    input wire logic sckLink,
    input wire logic frameSyncIn,
    input wire logic send_pcm_input,
    input wire logic recv_pcm_input,
    output logic send_pcm_output,
    output logic sendPcmOe,
    output logic recv_pcm_output,
    output logic recvPcmOe,
    input wire logic [CAS_W-1:0] cascadeDataIn,
    output logic [CAS_W-1:0] cascadeDataOut,
    output logic cascadeDataOe,
    input wire logic cascade_transfer_flag_in,
    output logic cascade_flag_out_a,
    output logic cascade_flag_out_b,
    output logic frame_sync_gen_out,
    output logic bit_clock_gen_out,
    output logic master_clock_out,
    output logic osc_drive_out,
    output logic cycle_done_out,
    output logic load_detect_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NSYNC = CAS_W + 8;
    localparam int IX_PDN = CAS_W;
    localparam int IX_FLAG = CAS_W + 1;
    localparam int IX_HOWL = CAS_W + 2;
    localparam int IX_SBIT = CAS_W + 3;
    localparam int IX_RBIT = CAS_W + 4;
    localparam int IX_OE = CAS_W + 5;
    localparam int IX_RXT = CAS_W + 6;
    localparam int IX_TXACK = CAS_W + 7;

    logic sendBit, recvBit, bitOe, rxTgl, txAck;
    logic [PCM_W-1:0] rxSendHold, rxRecvHold;
    wire [NSYNC-1:0] syncIn = {txAck, rxTgl, bitOe, recvBit, sendBit, howl_detector_ctrl_n,
                               cascade_transfer_flag_in, power_down_n, cascadeDataIn};
    logic [NSYNC-1:0] filt_r;

    // One three-stage filter per input bit
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic [SYNC_STAGES-1:0] st_r;
            always_ff @(posedge clk_sys) begin
                st_r <= {st_r[SYNC_STAGES-2:0], syncIn[gi]};
                if (!rstn) begin
                    filt_r[gi] <= (gi == IX_PDN || gi == IX_FLAG) ? 1'b1 : 1'b0;
                end else if (st_r[1] == st_r[2]) begin
                    filt_r[gi] <= st_r[2];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Power-down, internal reset and initialisation window
    logic pdActive_r, flagPrev_r, rxTglSeen_r, haltLink_r;
    logic [$clog2(INIT_CYCLES+1)-1:0] initCnt_r;
    wire pdNow = !filt_r[IX_PDN];
    wire coreRst = !rstn || pdActive_r;
    wire initBusy = (initCnt_r != '0);
    wire ignoreIn = pdActive_r || initBusy;

    // Power-down follows the filtered pin; internal reset holds the init counter loaded, release starts its count
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pdActive_r <= 1'b0;
        end else begin
            pdActive_r <= pdNow;
        end
        haltLink_r <= coreRst || initBusy; // Link stays halted through init as well
        if (coreRst) begin
            initCnt_r <= INIT_CYCLES[$bits(initCnt_r)-1:0];
        end else if (initBusy) begin
            initCnt_r <= initCnt_r - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [CTRL_W-1:0] ctrl_r;
    logic [PCM_W-1:0] txSend_r, txRecv_r, rxSend_r, rxRecv_r, txSendHs_r, txRecvHs_r;
    logic [CAS_W-1:0] casOut_r, casIn_r;
    logic txTgl_r, rxNew_r, casNew_r, txPend_r;
    wire txLaunch = txPend_r && (filt_r[IX_TXACK] == txTgl_r); // Link caught up
    wire wrEn = busWr && !pdActive_r;
    wire wrCtrl = wrEn && (busAddr == REG_CTRL);
    wire wrTxS = wrEn && (busAddr == REG_TX_SEND);
    wire wrTxR = wrEn && (busAddr == REG_TX_RECV);
    wire wrCas = wrEn && (busAddr == REG_CAS_OUT);
    wire rdRx = busRd && (busAddr == REG_RX_RECV);
    wire rdCas = busRd && (busAddr == REG_CAS_IN);
    wire rxEvent = (filt_r[IX_RXT] != rxTglSeen_r) && !ignoreIn;
    wire casFall = flagPrev_r && !filt_r[IX_FLAG];
    wire casEvent = casFall && !ignoreIn;
    wire isSlave = ctrl_r[CTRL_SLAVE];
    wire howlEn = !isSlave && !filt_r[IX_HOWL];
    wire howlBad = isSlave && filt_r[IX_HOWL];
    wire [DATA_W-1:0] statusWord = {10'h000, casNew_r, rxNew_r, howlBad, howlEn,
                                    initBusy, pdActive_r};

    // Control, sample and cascade registers; internal reset clears all but ctrl_r, which loads CTRL_RST
    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            ctrl_r <= CTRL_RST;
            txSend_r <= '0;
            txRecv_r <= '0;
            casOut_r <= '0;
            txTgl_r <= 1'b0;
            txPend_r <= 1'b0;
            txSendHs_r <= '0;
            txRecvHs_r <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl_r <= busWrData[CTRL_W-1:0];
            end
            if (wrTxS) begin
                txSend_r <= busWrData[PCM_W-1:0];
            end
            if (wrTxR) begin
                txRecv_r <= busWrData[PCM_W-1:0];
            end
            if (txLaunch) begin
                txSendHs_r <= txSend_r;
                txRecvHs_r <= txRecv_r;
                txTgl_r <= !txTgl_r;
            end
            txPend_r <= wrTxS || wrTxR || (txPend_r && !txLaunch);
            if (wrCas) begin
                casOut_r <= busWrData;
            end
        end
    end

    // Captured words and their sticky flags; a new event beats a read clear
    always_ff @(posedge clk_sys) begin
        flagPrev_r <= filt_r[IX_FLAG];
        rxTglSeen_r <= filt_r[IX_RXT];
        if (coreRst) begin
            rxSend_r <= '0;
            rxRecv_r <= '0;
            casIn_r <= '0;
            rxNew_r <= 1'b0;
            casNew_r <= 1'b0;
        end else begin
            if (rxEvent) begin
                rxSend_r <= rxSendHold;
                rxRecv_r <= rxRecvHold;
            end
            if (casEvent) begin
                casIn_r <= filt_r[CAS_W-1:0];
            end
            rxNew_r <= rxEvent || (rxNew_r && !rdRx);
            casNew_r <= casEvent || (casNew_r && !rdCas);
        end
    end

    // Read mux; unmapped indices read zero
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        case (busAddr)
            REG_CTRL: rdMux = {11'h000, ctrl_r};
            REG_STATUS: rdMux = statusWord;
            REG_TX_SEND: rdMux = {8'h00, txSend_r};
            REG_TX_RECV: rdMux = {8'h00, txRecv_r};
            REG_RX_SEND: rdMux = {8'h00, rxSend_r};
            REG_RX_RECV: rdMux = {8'h00, rxRecv_r};
            REG_CAS_OUT: rdMux = casOut_r;
            REG_CAS_IN: rdMux = casIn_r;
            default: rdMux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            busRdData <= 16'h0000;
        end else begin
            busRdData <= busRd ? rdMux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial link on the bit clock
    ec_pcm_link ec_pcm_link_i (
        .sckLink(sckLink),
        .haltReq(haltLink_r),
        .frameSyncIn(frameSyncIn),
        .sendPcmIn(send_pcm_input),
        .recvPcmIn(recv_pcm_input),
        .txSendStage(txSendHs_r),
        .txRecvStage(txRecvHs_r),
        .txTgl(txTgl_r),
        .sendBit(sendBit),
        .recvBit(recvBit),
        .bitOe(bitOe),
        .rxSendHold(rxSendHold),
        .rxRecvHold(rxRecvHold),
        .rxTgl(rxTgl),
        .txAck(txAck)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers: PCM, cascade bus, flags
    wire casDrive = ctrl_r[CTRL_CAS_DRIVE] && !ignoreIn;

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            sendPcmOe <= 1'b0;
            recvPcmOe <= 1'b0;
            cascadeDataOe <= 1'b0;
            send_pcm_output <= 1'b0;
            recv_pcm_output <= 1'b0;
            cascadeDataOut <= '0;
            cascade_flag_out_a <= 1'b1;
            cascade_flag_out_b <= 1'b1;
        end else begin
            sendPcmOe <= filt_r[IX_OE];
            recvPcmOe <= filt_r[IX_OE];
            send_pcm_output <= filt_r[IX_SBIT];
            recv_pcm_output <= filt_r[IX_RBIT];
            cascadeDataOe <= casDrive;
            cascadeDataOut <= casOut_r;
            cascade_flag_out_a <= ctrl_r[CTRL_FLAG_A];
            cascade_flag_out_b <= ctrl_r[CTRL_FLAG_B];
        end
    end

    // Done and load-detect outputs hold their last level in power-down
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cycle_done_out <= 1'b0;
            load_detect_out <= 1'b1;
        end else if (!pdActive_r) begin
            cycle_done_out <= ctrl_r[CTRL_CYCLE_DONE];
            load_detect_out <= !rxEvent; // Low for one cycle per loaded pair
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Generated bit clock, frame sync and master clock
    logic [$clog2(BCLK_HALF_CYC)-1:0] divCnt_r;
    logic [$clog2(BITS_PER_FRAME)-1:0] bitIdx_r;
    wire divWrap = (divCnt_r == ($bits(divCnt_r))'(BCLK_HALF_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            divCnt_r <= '0;
            bitIdx_r <= '0;
            bit_clock_gen_out <= 1'b0;
            frame_sync_gen_out <= 1'b0;
            master_clock_out <= 1'b0;
            osc_drive_out <= !rstn ? 1'b0 : 1'b1;
        end else begin
            master_clock_out <= !master_clock_out;
            osc_drive_out <= 1'b0;
            divCnt_r <= divWrap ? '0 : divCnt_r + 1'b1;
            if (divWrap) begin
                bit_clock_gen_out <= !bit_clock_gen_out;
                if (!bit_clock_gen_out) begin
                    bitIdx_r <= bitIdx_r + 1'b1;
                    frame_sync_gen_out <= (bitIdx_r == '1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_pd_enter;
        @(posedge clk_sys) disable iff (!rstn)
        pdNow |=> pdActive_r;
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("Power-down not entered");

    property p_pd_float;
        @(posedge clk_sys) disable iff (!rstn)
        pdActive_r |=> !sendPcmOe && !recvPcmOe && !cascadeDataOe;
    endproperty
    a_pd_float: assert property (p_pd_float) else $error("Output driven in power-down");

    property p_pd_levels;
        @(posedge clk_sys) disable iff (!rstn)
        pdActive_r |=> !frame_sync_gen_out && !bit_clock_gen_out && !master_clock_out
            && cascade_flag_out_a && cascade_flag_out_b && osc_drive_out;
    endproperty
    a_pd_levels: assert property (p_pd_levels) else $error("Wrong power-down levels");

    property p_pd_freeze;
        @(posedge clk_sys) disable iff (!rstn)
        pdActive_r && $past(pdActive_r) |-> $stable(cycle_done_out) && $stable(load_detect_out);
    endproperty
    a_pd_freeze: assert property (p_pd_freeze) else $error("Held output moved");

    property p_release_reset;
        @(posedge clk_sys) disable iff (!rstn)
        $fell(pdActive_r) |-> ctrl_r == CTRL_RST && initBusy && casIn_r == '0;
    endproperty
    a_release_reset: assert property (p_release_reset) else $error("No reset on release");

    property p_init_ignore;
        @(posedge clk_sys) disable iff (!rstn)
        initBusy |=> $stable(casIn_r) && $stable(rxRecv_r);
    endproperty
    a_init_ignore: assert property (p_init_ignore) else $error("Input taken during init");

    property p_cas_capture;
        @(posedge clk_sys) disable iff (!rstn)
        casFall && !ignoreIn && !pdNow |=> casIn_r == $past(filt_r[CAS_W-1:0]) && casNew_r;
    endproperty
    a_cas_capture: assert property (p_cas_capture) else $error("Cascade word missed");

    property p_cas_oe;
        @(posedge clk_sys) disable iff (!rstn)
        cascadeDataOe |-> $past(ctrl_r[CTRL_CAS_DRIVE]) && !$past(ignoreIn);
    endproperty
    a_cas_oe: assert property (p_cas_oe) else $error("Cascade bus driven unasked");

    property p_howl;
        @(posedge clk_sys) disable iff (!rstn)
        busRd && busAddr == REG_STATUS |=> busRdData[ST_HOWL_EN] == $past(howlEn);
    endproperty
    a_howl: assert property (p_howl) else $error("Howl status wrong");

endmodule // echo_canceler_port

// File: pcm_codec_model.sv
// Purpose: Behavioural PCM codec on the far side of the serial link.
// Assumes: Bit clock runs free; 32 bit slots to a frame.
// Notes:   Released data lines toggle so that stale bits never look valid.
`timescale 1ns/10ps
module pcm_codec_model (
    input wire logic sckLink,
    input wire logic [7:0] sendByte,
    input wire logic [7:0] recvByte,
    input wire logic sendOut,
    input wire logic sendOe,
    input wire logic recvOut,
    input wire logic recvOe,
    output logic frameSync = 1'b0,
    output logic sendIn = 1'b0,
    output logic recvIn = 1'b1,
    output logic [7:0] sendSeen = 8'h00,
    output logic [7:0] recvSeen = 8'h00
);
    logic [4:0] slot = 5'h00;
    ////////////////////////////////////////////////////////////////////////////////
    // Sync for one slot a frame, then both samples MSB first from the sync edge
    always @(posedge sckLink) begin
        slot <= slot + 5'h01;
        frameSync <= (slot == 5'h1f);
        sendIn <= (slot < 5'h08) ? sendByte[3'h7 - slot[2:0]] : ~sendIn;
        recvIn <= (slot < 5'h08) ? recvByte[3'h7 - slot[2:0]] : ~recvIn;
    end
    // Collect what the device shifts out while it drives
    always @(negedge sckLink) begin
        if (sendOe) begin
            sendSeen <= {sendSeen[6:0], sendOut};
        end
        if (recvOe) begin
            recvSeen <= {recvSeen[6:0], recvOut};
        end
    end
endmodule // pcm_codec_model

// File: echo_canceler_port_bench.sv
// Purpose: Self-checking bench for the echo-canceller port block.
// Assumes: Short init window of 200 cycles; codec model on the link.
// Notes:   Bus strobes change just after rising clk_sys edges.
`timescale 1ns/10ps
module echo_canceler_port_bench;
    import ec_port_pkg::*;
    logic clk_sys = 1'b0;
    logic sckLink = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] busAddr = 4'h0;
    logic [15:0] busWrData = 16'h0000;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic powerDownN = 1'b1;
    logic howlN = 1'b0;
    logic casFlag = 1'b1;
    logic [15:0] casIn = 16'h0000;
    logic [15:0] rdData;
    logic [15:0] casOut;
    logic frameSync, sendIn, recvIn, sendOut, sendOe, recvOut, recvOe, casOe, flagA, flagB;
    logic fsGen, bcGen, mclk, osc, cycDone, ldOut;
    logic [7:0] sendSeen, recvSeen;
    logic [15:0] s;
    int numErrors = 0;
    int nCompared = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: core at 5 ns, link at 80 ns with an unrelated phase
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #13;
        forever #40 sckLink = ~sckLink;
    end
    echo_canceler_port #(.INIT_CYCLES(200)) echo_canceler_port_i (.clk_sys(clk_sys),
        .rstn(rstn), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
        .busRdData(rdData), .power_down_n(powerDownN), .howl_detector_ctrl_n(howlN),
        .sckLink(sckLink), .frameSyncIn(frameSync), .send_pcm_input(sendIn),
        .recv_pcm_input(recvIn), .send_pcm_output(sendOut), .sendPcmOe(sendOe),
        .recv_pcm_output(recvOut), .recvPcmOe(recvOe), .cascadeDataIn(casIn),
        .cascadeDataOut(casOut), .cascadeDataOe(casOe), .cascade_transfer_flag_in(casFlag),
        .cascade_flag_out_a(flagA), .cascade_flag_out_b(flagB), .frame_sync_gen_out(fsGen),
        .bit_clock_gen_out(bcGen), .master_clock_out(mclk), .osc_drive_out(osc),
        .cycle_done_out(cycDone), .load_detect_out(ldOut));
    pcm_codec_model pcm_codec_model_i (.sckLink(sckLink), .sendByte(8'h96),
        .recvByte(8'h5e), .sendOut(sendOut), .sendOe(sendOe), .recvOut(recvOut),
        .recvOe(recvOe), .frameSync(frameSync), .sendIn(sendIn), .recvIn(recvIn),
        .sendSeen(sendSeen), .recvSeen(recvSeen));
    ////////////////////////////////////////////////////////////////////////////////
    // Shared comparison, bus cycles and waits
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge clk_sys);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk_sys);
        busRd <= 1'b0;
        @(posedge clk_sys);
        s = rdData;
    endtask
    task automatic waitLoad;
        int i;
        for (i = 0; i < 3000 && ldOut !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
        if (i == 3000) begin
            numErrors++;
            print_verdict;
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic testPcm;
        wr(REG_TX_SEND, 16'h00a5);
        wr(REG_TX_RECV, 16'h003c);
        cycles(1600);
        waitLoad;
        chk("sendSeen", {8'h00, sendSeen}, 16'h00a5);
        chk("recvSeen", {8'h00, recvSeen}, 16'h003c);
        cycles(20);
        chk("pcmOe", {14'h0, sendOe, recvOe}, 16'h0000);
        rd(REG_RX_SEND);
        chk("rxSend", s, 16'h0096);
        rd(REG_RX_RECV);
        chk("rxRecv", s, 16'h005e);
        $display("done testPcm");
    endtask
    task automatic testHowl;
        howlN <= 1'b1;
        cycles(10);
        rd(REG_STATUS);
        chk("howlOff", {15'h0, s[ST_HOWL_EN]}, 16'h0000);
        wr(REG_CTRL, 16'h000d);
        cycles(4);
        rd(REG_STATUS);
        chk("slaveHowl", {15'h0, s[ST_HOWL_BAD]}, 16'h0001);
        wr(REG_CTRL, 16'h000c);
        howlN <= 1'b0;
        cycles(10);
        rd(REG_STATUS);
        chk("howlOn", {15'h0, s[ST_HOWL_EN]}, 16'h0001);
        $display("done testHowl");
    endtask
    task automatic testCascade;
        wr(REG_CAS_OUT, 16'h8001);
        wr(REG_CTRL, 16'h000e);
        cycles(3);
        chk("casDrive", {casOe, casOut[15:1]}, 16'hc000);
        wr(REG_CTRL, 16'h000c);
        casIn <= 16'hc3a5;
        cycles(4);
        chk("casFloat", {15'h0, casOe}, 16'h0000);
        casFlag <= 1'b0;
        cycles(12);
        rd(REG_CAS_IN);
        chk("casCapture", s, 16'hc3a5);
        casIn <= 16'h1234;
        cycles(12);
        casFlag <= 1'b1;
        cycles(12);
        rd(REG_CAS_IN);
        chk("casNoRise", s, 16'hc3a5);
        $display("done testCascade");
    endtask
    task automatic testPowerDown;
        wr(REG_CTRL, 16'h0012);
        powerDownN <= 1'b0;
        casIn <= 16'h00ff;
        cycles(8);
        chk("pdFloat", {13'h0, sendOe, recvOe, casOe}, 16'h0000);
        chk("pdLow", {13'h0, fsGen, bcGen, mclk}, 16'h0000);
        chk("pdHigh", {12'h0, flagA, flagB, osc, ldOut}, 16'h000f);
        chk("pdFrozen", {15'h0, cycDone}, 16'h0001);
        casFlag <= 1'b0;
        wr(REG_CTRL, 16'h0002);
        chk("pdMclk", {15'h0, mclk}, 16'h0000);
        rd(REG_STATUS);
        chk("pdStatus", {15'h0, s[ST_PD]}, 16'h0001);
        casFlag <= 1'b1;
        powerDownN <= 1'b1;
        cycles(6);
        rd(REG_STATUS);
        chk("initBusy", {15'h0, s[ST_INIT]}, 16'h0001);
        casFlag <= 1'b0;
        rd(REG_CTRL);
        chk("ctrlReset", s, 16'h000c);
        chk("cycDoneReset", {15'h0, cycDone}, 16'h0000);
        cycles(60);
        rd(REG_CAS_IN);
        chk("casIgnored", s, 16'h0000);
        s[0] = mclk;
        cycles(1);
        chk("mclkRuns", {15'h0, s[0] ^ mclk}, 16'h0001);
        casFlag <= 1'b1;
        $display("done testPowerDown");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        cycles(4);
        rstn <= 1'b1;
        rd(4'h8);
        chk("unmapped", s, 16'h0000);
        cycles(300);
        testPcm;
        testHowl;
        testCascade;
        testPowerDown;
        print_verdict;
    end
endmodule // echo_canceler_port_bench
